// [core/ilt_capture_timer.sv]
/*
 * Capture period timer: counts a fixed number of clock cycles after a
 * start pulse and gives a one-cycle expiry pulse unless i_abort ends the count first.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`include "ilt_defs.svh"

module ilt_capture_timer #(
	parameter int unsigned CYCLES = `ILT_CAPTURE_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_start,
	input wire logic i_abort,
	output logic o_running,
	output logic o_expired
);

	ilt_pkg::ilt_tmr_s st_reg;
	ilt_pkg::ilt_tmr_s st_next;

	always_comb begin
		st_next = st_reg;
		st_next.expired = 1'b0;
		if (i_start) begin
			st_next.count = ilt_pkg::ilt_count_t'(CYCLES - 1);
			st_next.running = 1'b1;
		end else if (i_abort) begin
			st_next.running = 1'b0;
		end else if (st_reg.running) begin
			if (st_reg.count == '0) begin
				st_next.running = 1'b0;
				st_next.expired = 1'b1;
			end else begin
				st_next.count = st_reg.count - 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_running = st_reg.running;
	assign o_expired = st_reg.expired;

endmodule

// [core/ilt_defs.svh]
/*
 * Register map, field positions, reset values and timing figures for the
 * identity and lock test register bank.
 * Assumes the including file supplies nothing beforehand.
 */
`ifndef ILT_DEFS_SVH
`define ILT_DEFS_SVH

// Register offsets on the microprocessor port
`define ILT_ADDR_CODE_LOW 8'h00
`define ILT_ADDR_CODE_HIGH 8'h01
`define ILT_ADDR_REVISION 8'h02
`define ILT_ADDR_DIAG 8'h03

// Diagnostic lock control fields
`define ILT_DIAG_RESET 7'h14
`define ILT_DIAG_WMASK 7'h5F
`define ILT_BIT_DISABLE_180 6
`define ILT_BIT_ALARM 7
`define ILT_READ_ZERO 8'h00

// Neutral identity values, arbitrary
`define ILT_DEVICE_CODE 16'hA5C3
`define ILT_REVISION_CODE 8'h01

// Timing
`define ILT_CLK_HZ 10000000
`define ILT_CAPTURE_S 2
`define ILT_CAPTURE_CYCLES (`ILT_CAPTURE_S * `ILT_CLK_HZ)

`endif

// [core/ilt_pkg.sv]
/*
 * Types shared by the identity and lock test register bank.
 * Assumes ilt_defs.svh supplies the numeric constants.
 */
package ilt_pkg;

	typedef logic [31:0] ilt_count_t;

	typedef enum logic [1:0] {
		ILT_ST_IDLE = 2'b00,
		ILT_ST_CAPTURE = 2'b01,
		ILT_ST_NEAREST = 2'b10,
		ILT_ST_WIDE = 2'b11
	} ilt_mode_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ilt_bus_s;

	typedef struct packed {
		ilt_mode_e mode;
		logic [6:0] ctrl;
		logic [7:0] rdata;
		logic rvalid;
		logic wide;
	} ilt_top_s;

	typedef struct packed {
		ilt_count_t count;
		logic running;
		logic expired;
	} ilt_tmr_s;

endpackage

// [core/ilt_regs.sv]
/*
 * Identity and lock test register bank with capture mode control for the
 * primary digital loop.
 * Assumes a byte-wide register port synchronous to I_CLK, and loop status
 * inputs that are already synchronous.
 */
`timescale 1ns/10ps
`include "ilt_defs.svh"

module ilt_regs #(
	parameter int unsigned CAPTURE_CYCLES = `ILT_CAPTURE_CYCLES,
	// Arbitrary identity values
	parameter logic [15:0] DEVICE_CODE = `ILT_DEVICE_CODE,
	parameter logic [7:0] REVISION_CODE = `ILT_REVISION_CODE
) (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR_EN,
	input wire logic I_RD_EN,
	input wire logic I_NEW_REF,
	input wire logic I_PHASE_LOCKED,
	input wire logic I_PHASE_ALARM,
	output logic [7:0] O_RDATA,
	output logic O_RD_VALID,
	output logic O_CAPTURE_ACTIVE,
	output logic O_RANGE_WIDE,
	output logic [6:0] O_DIAG_CTRL
);

	ilt_pkg::ilt_bus_s bus;
	ilt_pkg::ilt_top_s st_reg;
	ilt_pkg::ilt_top_s st_next;
	logic disable_180;
	logic tmr_start;
	logic tmr_abort;
	logic tmr_running;
	logic tmr_expired;

	function automatic logic [7:0] read_word(
		input logic [7:0] addr,
		input logic [6:0] ctrl,
		input logic alarm
	);
		logic [7:0] val;
		val = `ILT_READ_ZERO;
		unique case (addr)
			`ILT_ADDR_CODE_LOW: val = DEVICE_CODE[7:0];
			`ILT_ADDR_CODE_HIGH: val = DEVICE_CODE[15:8];
			`ILT_ADDR_REVISION: val = REVISION_CODE;
			`ILT_ADDR_DIAG: val = {alarm, ctrl};
			default: val = `ILT_READ_ZERO;
		endcase
		return val;
	endfunction

	assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR_EN, rd: I_RD_EN};
	assign disable_180 = st_reg.ctrl[`ILT_BIT_DISABLE_180];

	assign tmr_start = I_NEW_REF && !disable_180;
	assign tmr_abort = disable_180 && (st_reg.mode == ilt_pkg::ILT_ST_CAPTURE);

	ilt_capture_timer #(
		.CYCLES(CAPTURE_CYCLES)
	) ilt_capture_timer_i (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_start(tmr_start),
		.i_abort(tmr_abort),
		.o_running(tmr_running),
		.o_expired(tmr_expired)
	);

	always_comb begin
		st_next = st_reg;
		st_next.rvalid = bus.rd;
		// identity bytes have no write path
		if (bus.wr && bus.addr == `ILT_ADDR_DIAG) begin
			st_next.ctrl = bus.wdata[6:0] & `ILT_DIAG_WMASK;
		end
		if (bus.rd) begin
			st_next.rdata = read_word(bus.addr, st_reg.ctrl, I_PHASE_ALARM);
		end
		unique case (st_reg.mode)
			ilt_pkg::ILT_ST_IDLE,
			ilt_pkg::ILT_ST_NEAREST,
			ilt_pkg::ILT_ST_WIDE: begin
				if (I_NEW_REF) begin
					st_next.mode = disable_180 ? ilt_pkg::ILT_ST_WIDE :
						ilt_pkg::ILT_ST_CAPTURE;
				end
			end
			ilt_pkg::ILT_ST_CAPTURE: begin
				if (disable_180) begin
					st_next.mode = ilt_pkg::ILT_ST_WIDE;
				end else if (I_NEW_REF) begin
					st_next.mode = ilt_pkg::ILT_ST_CAPTURE;
				end else if (tmr_expired) begin
					st_next.mode = I_PHASE_LOCKED ? ilt_pkg::ILT_ST_NEAREST :
						ilt_pkg::ILT_ST_WIDE;
				end
			end
		endcase
		st_next.wide = (st_next.mode == ilt_pkg::ILT_ST_WIDE);
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_B) begin
			st_reg.mode <= ilt_pkg::ILT_ST_IDLE;
			st_reg.ctrl <= `ILT_DIAG_RESET;
			st_reg.rdata <= `ILT_READ_ZERO;
			st_reg.rvalid <= 1'b0;
			st_reg.wide <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign O_RDATA = st_reg.rdata;
	assign O_RD_VALID = st_reg.rvalid;
	assign O_CAPTURE_ACTIVE = (st_reg.mode == ilt_pkg::ILT_ST_CAPTURE);
	assign O_RANGE_WIDE = st_reg.wide;
	assign O_DIAG_CTRL = st_reg.ctrl;

	a_code_low_read: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(I_RD_EN && I_ADDR == `ILT_ADDR_CODE_LOW) |=>
			(O_RD_VALID && O_RDATA == DEVICE_CODE[7:0]))
		else $error("device code low byte wrong");

	a_code_high_read: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(I_RD_EN && I_ADDR == `ILT_ADDR_CODE_HIGH) |=>
			(O_RDATA == DEVICE_CODE[15:8]))
		else $error("device code high byte wrong");

	a_revision_read: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(I_RD_EN && I_ADDR == `ILT_ADDR_REVISION) |=>
			(O_RDATA == REVISION_CODE))
		else $error("revision byte wrong");

	a_capture_start: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(I_NEW_REF && !disable_180) |=>
			(O_CAPTURE_ACTIVE && !O_RANGE_WIDE && tmr_running))
		else $error("capture period not started");

	a_widen_unlocked: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(O_CAPTURE_ACTIVE && tmr_expired && !I_NEW_REF && !disable_180 &&
			!I_PHASE_LOCKED) |=> (O_RANGE_WIDE && !O_CAPTURE_ACTIVE))
		else $error("range not widened after capture");

	a_forced_leave: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(O_CAPTURE_ACTIVE && disable_180) |=>
			(O_RANGE_WIDE && !O_CAPTURE_ACTIVE ##1 !tmr_running))
		else $error("forced mode kept capture");

	a_forced_no_wait: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(I_NEW_REF && disable_180) |=> (O_RANGE_WIDE && !O_CAPTURE_ACTIVE))
		else $error("forced lock waited");

	a_alarm_live: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(I_RD_EN && I_ADDR == `ILT_ADDR_DIAG) |=>
			(O_RDATA[`ILT_BIT_ALARM] == $past(I_PHASE_ALARM)))
		else $error("phase alarm bit not live");

	a_read_pulse: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		!I_RD_EN |=> !O_RD_VALID)
		else $error("read valid without read");

	a_rdata_held: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		!I_RD_EN |=> $stable(O_RDATA))
		else $error("read data changed without read");

	a_unmapped_zero: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(I_RD_EN && I_ADDR > `ILT_ADDR_DIAG) |=>
			(O_RDATA == `ILT_READ_ZERO))
		else $error("unmapped read not zero");

	a_ctrl_write: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(I_WR_EN && I_ADDR == `ILT_ADDR_DIAG) |=>
			(O_DIAG_CTRL == ($past(I_WDATA[6:0]) & `ILT_DIAG_WMASK)))
		else $error("control write not applied");

	a_ctrl_kept: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		!(I_WR_EN && I_ADDR == `ILT_ADDR_DIAG) |=> $stable(O_DIAG_CTRL))
		else $error("control changed without write");

	a_locked_nearest: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(O_CAPTURE_ACTIVE && tmr_expired && !I_NEW_REF && !disable_180 &&
			I_PHASE_LOCKED) |=> (!O_RANGE_WIDE && !O_CAPTURE_ACTIVE))
		else $error("locked loop widened");

	a_wide_held: assert property (
		@(posedge I_CLK) disable iff (!I_RST_B)
		(O_RANGE_WIDE && !I_NEW_REF) |=> O_RANGE_WIDE)
		else $error("wide range dropped");

endmodule

// [verif/ilt_regs_tb.sv]
/*
 * Self-checking bench for the identity and lock test register bank.
 * Assumes ilt_regs and ilt_defs.svh are reachable on the include path.
 */
`timescale 1ns/10ps
`include "ilt_defs.svh"

module ilt_regs_tb;
	localparam int unsigned CYC = 10;
	logic clk;
	logic rst_b;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr_en;
	logic rd_en;
	logic new_ref;
	logic locked;
	logic alarm;
	logic [7:0] rdata;
	logic rd_valid;
	logic cap_act;
	logic wide;
	logic [6:0] ctrl;
	int error_cnt;
	int tests_run;

	ilt_regs #(.CAPTURE_CYCLES(CYC)) ilt_regs_i (
		.I_CLK(clk),
		.I_RST_B(rst_b),
		.I_ADDR(addr),
		.I_WDATA(wdata),
		.I_WR_EN(wr_en),
		.I_RD_EN(rd_en),
		.I_NEW_REF(new_ref),
		.I_PHASE_LOCKED(locked),
		.I_PHASE_ALARM(alarm),
		.O_RDATA(rdata),
		.O_RD_VALID(rd_valid),
		.O_CAPTURE_ACTIVE(cap_act),
		.O_RANGE_WIDE(wide),
		.O_DIAG_CTRL(ctrl)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			error_cnt++;
		end
	endtask

	// Read strobe for one cycle, data judged one cycle later
	task rd(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		check({7'h00, rd_valid}, 8'h01);
		check(rdata, exp);
		@(negedge clk);
		check({7'h00, rd_valid}, 8'h00);
		check(rdata, exp);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		@(negedge clk);
	endtask

	task t_ident;
		logic [15:0] code;
		code = `ILT_DEVICE_CODE;
		rd(8'h00, code[7:0]);
		rd(8'h01, code[15:8]);
		rd(8'h02, `ILT_REVISION_CODE);
		rd(8'h05, 8'h00);
		wr(8'h00, 8'hFF);
		wr(8'h01, 8'h00);
		wr(8'h02, 8'hFF);
		rd(8'h00, code[7:0]);
		rd(8'h01, code[15:8]);
		rd(8'h02, `ILT_REVISION_CODE);
		$display("identity test done");
	endtask

	task t_diag;
		check({1'b0, ctrl}, 8'h14);
		alarm = 1'b1;
		rd(8'h03, 8'h94);
		wr(8'h03, 8'hFF);
		check({1'b0, ctrl}, 8'h5F);
		rd(8'h03, 8'hDF);
		alarm = 1'b0;
		rd(8'h03, 8'h5F);
		wr(8'h03, 8'h00);
		check({1'b0, ctrl}, 8'h00);
		$display("diagnostic register test done");
	endtask

	task t_capture(input logic lk);
		locked = lk;
		new_ref = 1'b1;
		@(negedge clk);
		new_ref = 1'b0;
		check({6'h00, cap_act, wide}, 8'h02);
		repeat (CYC) @(negedge clk);
		check({7'h00, cap_act}, 8'h01);
		@(negedge clk);
		check({6'h00, cap_act, wide}, {7'h00, ~lk});
		$display("automatic capture test done");
	endtask

	task t_forced;
		wr(8'h03, 8'h40);
		check({1'b0, ctrl}, 8'h40);
		locked = 1'b1;
		new_ref = 1'b1;
		@(negedge clk);
		new_ref = 1'b0;
		check({6'h00, cap_act, wide}, 8'h01);
		repeat (3) @(negedge clk);
		check({6'h00, cap_act, wide}, 8'h01);
		wr(8'h03, 8'h00);
		new_ref = 1'b1;
		@(negedge clk);
		new_ref = 1'b0;
		check({6'h00, cap_act, wide}, 8'h02);
		wr(8'h03, 8'h40);
		check({6'h00, cap_act, wide}, 8'h01);
		$display("forced locking test done");
	endtask

	task t_reset(input int n);
		rst_b = 1'b0;
		repeat (n) @(negedge clk);
		rst_b = 1'b1;
		check({cap_act, ctrl}, 8'h14);
		check({6'h00, rd_valid, wide}, 8'h00);
		check(rdata, 8'h00);
		rd(8'h03, 8'h14);
		$display("reset test done");
	endtask

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end

	initial begin
		error_cnt = 0;
		tests_run = 0;
		addr = 8'h00;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		new_ref = 1'b0;
		locked = 1'b0;
		alarm = 1'b0;
		t_reset(5);
		t_ident();
		t_diag();
		t_capture(1'b0);
		t_capture(1'b1);
		t_forced();
		t_reset(1);
		report_and_stop();
	end
endmodule
